/* design/dsj_top.sv */
// Debug status/instruction/PC/mask registers reached over a JTAG TAP.
// Assumes JTAG pins arrive asynchronously; tck is sampled by clk_sys.
// Overview of operation
// - Status bit 4 set on debug entry from sleep, cleared on exit.
// - Status bit 3 set when hardware error caused debug entry.
// - Status bit 2 set on hardware breakpoint entry, cleared on exit.
// - Status bit 1 set on breakpoint instruction entry, cleared on exit.
// - Status bit 0 set on single step entry, cleared on exit.
// - 32-bit read/write instruction register, reset zero, fed to halted core.
// - Instruction register also holds instruction replacing a software breakpoint.
// - Program counter register tracks last executed non-debug instruction, non-intrusively.
// - In debug mode it holds last instruction executed before entry.
// - Written PC value used when the return instruction is replaced.
// - Feature mask holds written bits 5:1 until rewritten or debug reset.
// - Mask bits 5 and 4 keep imprecise execution and breakpoints.
// - Mask bits 3,2,1 keep return stack, folding, prediction enabled.
// - All register access goes over JTAG.
// - One shared TAP serves debug access and other test functions.
// - Debug access mode persists until Test-Logic-Reset is detected or another instruction is loaded.
// - Launch outgoing data on falling tck, sample on rising tck.
// - Active-low test reset asynchronously resets TAP, instruction and mask registers, not status or PC.
// - Status read-only, several flags may set, undefined outside debug.
`timescale 1ns/1ps
module dsj_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  input  wire logic        trst_n,
  output logic             tdo,
  output logic             tdo_oe_n,
  input  wire logic        debug_mode,
  input  wire logic        enter_debug,
  input  wire logic        cause_sleep,
  input  wire logic        cause_hw_err,
  input  wire logic        cause_hw_brk,
  input  wire logic        cause_sw_brk,
  input  wire logic        cause_step,
  input  wire logic [7:0]  breakpoint_hit_bits,
  input  wire logic        core_retire,
  input  wire logic [31:0] core_pc,
  output logic [31:0]      debug_instruction,
  output logic             inst_written,
  output logic [31:0]      debug_prog_counter,
  output logic             pc_written,
  output logic             imprecise_exec_keep,
  output logic             imprecise_bkpt_keep,
  output logic             return_stack_keep,
  output logic             folding_keep,
  output logic             predict_keep,
  output logic             dbg_access_mode
);
  // ==========================================================
  // Pin synchronisers; trst_n is a reset and acts directly
  logic [2:0] pins_s;
  dsj_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({tck, tms, tdi}),
    .rst_val (3'h0),
    .q       (pins_s)
  );
  wire tck_s  = pins_s[2];
  wire tms_s  = pins_s[1];
  wire tdi_s  = pins_s[0];
  logic tck_d_q;
  logic rst_j_q;
  // Asynchronous assert of JTAG reset, released on clk_sys
  always_ff @(posedge clk_sys or posedge rst or negedge trst_n) begin
    if (rst || !trst_n) rst_j_q <= 1'b1;
    else                rst_j_q <= 1'b0;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) tck_d_q <= 1'b0;
    else     tck_d_q <= tck_s;
  end
  wire tck_rise = tck_s & ~tck_d_q;
  wire tck_fall = ~tck_s & tck_d_q;
  // ==========================================================
  // TAP controller, shared for all test functions
  dsj_pkg::dsj_tap_e st_q, st_d;
  always_comb begin
    st_d = st_q;
    case (st_q)
      dsj_pkg::S_TLR:    st_d = tms_s ? dsj_pkg::S_TLR    : dsj_pkg::S_RTI;
      dsj_pkg::S_RTI:    st_d = tms_s ? dsj_pkg::S_SEL_DR : dsj_pkg::S_RTI;
      dsj_pkg::S_SEL_DR: st_d = tms_s ? dsj_pkg::S_SEL_IR : dsj_pkg::S_CAP_DR;
      dsj_pkg::S_CAP_DR: st_d = tms_s ? dsj_pkg::S_EX1_DR : dsj_pkg::S_SH_DR;
      dsj_pkg::S_SH_DR:  st_d = tms_s ? dsj_pkg::S_EX1_DR : dsj_pkg::S_SH_DR;
      dsj_pkg::S_EX1_DR: st_d = tms_s ? dsj_pkg::S_UP_DR  : dsj_pkg::S_PA_DR;
      dsj_pkg::S_PA_DR:  st_d = tms_s ? dsj_pkg::S_EX2_DR : dsj_pkg::S_PA_DR;
      dsj_pkg::S_EX2_DR: st_d = tms_s ? dsj_pkg::S_UP_DR  : dsj_pkg::S_SH_DR;
      dsj_pkg::S_UP_DR:  st_d = tms_s ? dsj_pkg::S_SEL_DR : dsj_pkg::S_RTI;
      dsj_pkg::S_SEL_IR: st_d = tms_s ? dsj_pkg::S_TLR    : dsj_pkg::S_CAP_IR;
      dsj_pkg::S_CAP_IR: st_d = tms_s ? dsj_pkg::S_EX1_IR : dsj_pkg::S_SH_IR;
      dsj_pkg::S_SH_IR:  st_d = tms_s ? dsj_pkg::S_EX1_IR : dsj_pkg::S_SH_IR;
      dsj_pkg::S_EX1_IR: st_d = tms_s ? dsj_pkg::S_UP_IR  : dsj_pkg::S_PA_IR;
      dsj_pkg::S_PA_IR:  st_d = tms_s ? dsj_pkg::S_EX2_IR : dsj_pkg::S_PA_IR;
      dsj_pkg::S_EX2_IR: st_d = tms_s ? dsj_pkg::S_UP_IR  : dsj_pkg::S_SH_IR;
      dsj_pkg::S_UP_IR:  st_d = tms_s ? dsj_pkg::S_SEL_DR : dsj_pkg::S_RTI;
      default:           st_d = dsj_pkg::S_TLR;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst_j_q) begin
    if (rst_j_q)       st_q <= dsj_pkg::S_TLR;
    else if (tck_rise) st_q <= st_d;
  end
  // ==========================================================
  // Instruction register
  logic [3:0] ir_sh_q, ir_q;
  wire in_tlr = (st_q == dsj_pkg::S_TLR);
  always_ff @(posedge clk_sys or posedge rst_j_q) begin
    if (rst_j_q) begin
      ir_sh_q <= 4'h0;
      ir_q    <= dsj_pkg::IR_IDCODE;
    end else if (tck_rise) begin
      if (st_q == dsj_pkg::S_CAP_IR) ir_sh_q <= 4'h1;
      else if (st_q == dsj_pkg::S_SH_IR) ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
      if (in_tlr) ir_q <= dsj_pkg::IR_IDCODE;
      else if (st_q == dsj_pkg::S_UP_IR) ir_q <= ir_sh_q;
    end
  end
  wire sel_dbg = (ir_q == dsj_pkg::IR_DBG_ACC);
  wire sel_id  = (ir_q == dsj_pkg::IR_IDCODE);
  // ==========================================================
  // Debug data path: command scan then data scan
  logic        phase_q;   // 0: next DR scan is a command
  logic [6:0]  addr_q;
  logic        wr_q;
  logic [31:0] dr_q;
  logic        byp_q;
  logic [31:0] status_q;
  logic [31:0] mask_q;
  logic [31:0] rd_word;
  assign rd_word = (addr_q == dsj_pkg::ADDR_STATUS) ? status_q           :
                   (addr_q == dsj_pkg::ADDR_INST)   ? debug_instruction  :
                   (addr_q == dsj_pkg::ADDR_PC)     ? debug_prog_counter :
                   (addr_q == dsj_pkg::ADDR_MASK)   ? mask_q             : 32'h0000_0000;
  wire cap_dr = tck_rise && st_q == dsj_pkg::S_CAP_DR;
  wire sh_dr  = tck_rise && st_q == dsj_pkg::S_SH_DR;
  wire up_dr  = tck_rise && st_q == dsj_pkg::S_UP_DR;
  wire do_wr  = up_dr && sel_dbg && phase_q && wr_q;
  wire [31:0] cap_word = sel_dbg ? (phase_q ? rd_word : 32'h0000_0000) :
                         sel_id  ? dsj_pkg::IDCODE_VAL : 32'h0000_0000;
  always_ff @(posedge clk_sys or posedge rst_j_q) begin
    if (rst_j_q) begin
      dr_q    <= 32'h0000_0000;
      byp_q   <= 1'b0;
      phase_q <= 1'b0;
      addr_q  <= 7'h00;
      wr_q    <= 1'b0;
    end else begin
      if (cap_dr) begin
        dr_q  <= cap_word;
        byp_q <= 1'b0;
      end else if (sh_dr) begin
        dr_q  <= (sel_dbg && !phase_q) ? {24'h000000, tdi_s, dr_q[7:1]}
                                      : {tdi_s, dr_q[31:1]};
        byp_q <= tdi_s;
      end
      if (in_tlr || !sel_dbg) phase_q <= 1'b0;
      else if (up_dr) begin
        phase_q <= ~phase_q;
        if (!phase_q) begin
          addr_q <= dr_q[6:0];
          wr_q   <= dr_q[7];
        end
      end
    end
  end
  // TDO launched on the falling edge, disabled outside shift states
  wire shifting = (st_q == dsj_pkg::S_SH_DR) || (st_q == dsj_pkg::S_SH_IR);
  wire tdo_bit  = (st_q == dsj_pkg::S_SH_IR) ? ir_sh_q[0] :
                  (sel_dbg || sel_id) ? dr_q[0] : byp_q;
  always_ff @(posedge clk_sys or posedge rst_j_q) begin
    if (rst_j_q) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo      <= tdo_bit;
      tdo_oe_n <= ~shifting;
    end
  end
  // ==========================================================
  // Status flags, captured at debug entry and cleared on exit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) status_q <= dsj_pkg::RESET_WORD;
    else if (!debug_mode) status_q <= dsj_pkg::RESET_WORD;
    else if (enter_debug) begin
      status_q[dsj_pkg::ST_SLEEP] <= cause_sleep;
      status_q[dsj_pkg::ST_HWERR] <= cause_hw_err;
      status_q[dsj_pkg::ST_HWBRK] <= cause_hw_brk;
      status_q[dsj_pkg::ST_SWBRK] <= cause_sw_brk;
      status_q[dsj_pkg::ST_STEP]  <= cause_step;
      status_q[dsj_pkg::ST_BP_LO +: 8] <= breakpoint_hit_bits;
    end
  end
  // ==========================================================
  // Instruction, PC and mask registers
  wire wr_inst = do_wr && addr_q == dsj_pkg::ADDR_INST;
  wire wr_pc   = do_wr && addr_q == dsj_pkg::ADDR_PC;
  wire wr_mask = do_wr && addr_q == dsj_pkg::ADDR_MASK;
  always_ff @(posedge clk_sys or posedge rst_j_q) begin
    if (rst_j_q) begin
      debug_instruction <= dsj_pkg::RESET_WORD;
      inst_written      <= 1'b0;
      mask_q            <= dsj_pkg::RESET_WORD;
    end else begin
      inst_written <= wr_inst;
      if (wr_inst) debug_instruction <= dr_q;
      if (wr_mask) mask_q <= dr_q & dsj_pkg::MASK_RW;
    end
  end
  // Core writes while running; a debugger write wins only while halted
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      debug_prog_counter <= dsj_pkg::RESET_WORD;
      pc_written         <= 1'b0;
    end else begin
      pc_written <= wr_pc && debug_mode;
      if (!debug_mode && core_retire) debug_prog_counter <= core_pc;
      else if (wr_pc && debug_mode)   debug_prog_counter <= dr_q;
    end
  end
  always_ff @(posedge clk_sys or posedge rst_j_q) begin
    if (rst_j_q) begin
      imprecise_exec_keep <= 1'b0;
      imprecise_bkpt_keep <= 1'b0;
      return_stack_keep   <= 1'b0;
      folding_keep        <= 1'b0;
      predict_keep        <= 1'b0;
      dbg_access_mode     <= 1'b0;
    end else begin
      imprecise_exec_keep <= mask_q[dsj_pkg::MK_IMP_EXEC];
      imprecise_bkpt_keep <= mask_q[dsj_pkg::MK_IMP_BKPT];
      return_stack_keep   <= mask_q[dsj_pkg::MK_RSTACK];
      folding_keep        <= mask_q[dsj_pkg::MK_FOLD];
      predict_keep        <= mask_q[dsj_pkg::MK_PREDICT];
      dbg_access_mode     <= sel_dbg;
    end
  end
endmodule

/* design/dsj_pkg.sv */
// Shared constants for the debug register access block.
// Assumes a 200 MHz system clock sampling the JTAG pins.
package dsj_pkg;
  // ==========================================================
  // JTAG instruction and register addressing
  localparam int          IR_W         = 4;
  localparam logic [3:0]  IR_BYPASS    = 4'hf;
  localparam logic [3:0]  IR_DBG_ACC   = 4'h8;   // Arbitrary opcode
  localparam logic [3:0]  IR_IDCODE    = 4'h1;
  localparam logic [31:0] IDCODE_VAL   = 32'h1234_5001; // Arbitrary value
  localparam int          ADDR_W       = 7;
  localparam int          CMD_W        = ADDR_W + 1;
  localparam logic [6:0]  ADDR_STATUS  = 7'h01;
  localparam logic [6:0]  ADDR_INST    = 7'h02;
  localparam logic [6:0]  ADDR_PC      = 7'h03;
  localparam logic [6:0]  ADDR_MASK    = 7'h04;
  // ==========================================================
  // Field positions
  localparam int          ST_STEP      = 0;
  localparam int          ST_SWBRK     = 1;
  localparam int          ST_HWBRK     = 2;
  localparam int          ST_HWERR     = 3;
  localparam int          ST_SLEEP     = 4;
  localparam int          ST_BP_LO     = 8;
  localparam logic [31:0] MASK_RW      = 32'h0000_003e;
  localparam int          MK_PREDICT   = 1;
  localparam int          MK_FOLD      = 2;
  localparam int          MK_RSTACK    = 3;
  localparam int          MK_IMP_BKPT  = 4;
  localparam int          MK_IMP_EXEC  = 5;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  // ==========================================================
  // TAP states
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR,
    S_UP_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UP_IR
  } dsj_tap_e;
endpackage

/* design/dsj_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module dsj_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* sim/dsj_checker.sv */
// Port assertions for the debug register access block.
// Bound to dsj_top; sees only its ports.
`timescale 1ns/1ps
module dsj_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        tck,
  input wire logic        tms,
  input wire logic        trst_n,
  input wire logic        tdo,
  input wire logic        tdo_oe_n,
  input wire logic        debug_mode,
  input wire logic        core_retire,
  input wire logic [31:0] core_pc,
  input wire logic [31:0] debug_instruction,
  input wire logic        inst_written,
  input wire logic [31:0] debug_prog_counter,
  input wire logic        pc_written,
  input wire logic        imprecise_exec_keep,
  input wire logic        imprecise_bkpt_keep,
  input wire logic        return_stack_keep,
  input wire logic        folding_keep,
  input wire logic        predict_keep,
  input wire logic        dbg_access_mode
);
  // ==========================================
  // Cycles since tms was last high; an IR update or TLR needs tms high
  logic [4:0] tms_age_q;
  wire  [4:0] keeps = {imprecise_exec_keep, imprecise_bkpt_keep, return_stack_keep,
                       folding_keep, predict_keep};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) tms_age_q <= 5'h00;
    else if (tms) tms_age_q <= 5'h00;
    else if (tms_age_q != 5'h1f) tms_age_q <= tms_age_q + 5'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================
  // Assertions
  chk_jtag_reset: assert property (!trst_n |-> tdo_oe_n && !tdo && debug_instruction == 32'h0)
    else $error("jtag reset left tdo or instruction active");
  chk_reset_keep: assert property (!trst_n |-> keeps == 5'h00 && !dbg_access_mode)
    else $error("jtag reset left mask or access mode set");
  chk_inst_cause: assert property ($changed(debug_instruction) |-> inst_written ||
    $past(inst_written) || !trst_n || !$past(trst_n)) else $error("instruction changed unasked");
  chk_keep_cause: assert property ($changed(keeps) |-> dbg_access_mode ||
    !trst_n || !$past(trst_n)) else $error("mask changed outside access mode");
  chk_pc_write: assert property (pc_written |-> debug_mode || $past(debug_mode))
    else $error("pc written outside debug mode");
  chk_pc_track: assert property (core_retire && !debug_mode |-> ##2
    debug_prog_counter == $past(core_pc, 2)) else $error("pc not captured on retire");
  chk_mode_hold: assert property ($fell(dbg_access_mode) |-> tms_age_q < 5'h14 || !trst_n)
    else $error("access mode dropped without tms");
  chk_tdo_launch: assert property ($changed(tdo) |-> !$past(tck) || !trst_n ||
    !$past(trst_n)) else $error("tdo changed while tck high");
  cover property (inst_written);
  cover property (pc_written);
  cover property ($fell(dbg_access_mode));
endmodule
bind dsj_top dsj_checker u_chk (.*);

/* sim/dsj_probe.sv */
// JTAG debugger model for the debug register access block.
// Assumes the bench resolves tdo with a pull-up when released.
`timescale 1ns/1ps
module dsj_probe (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // tck stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // ==========================================
  // Pins change after the fall, tdo is taken at the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #32 tck = 1'b1;
    o = tdo;
    #32 tck = 1'b0;
  endtask
  // Idle tdi toggles so a stale bit cannot pass as data
  task automatic walk(input logic [7:0] path, input int n);
    logic o;
    for (int i = 0; i < n; i++) tick(path[i], ~tdi, o);
  endtask
  task automatic to_reset();
    walk(8'h1f, 6);
  endtask
  // From Run-Test/Idle through one IR or DR scan back to Run-Test/Idle
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    walk(8'h01, 2);
  endtask
  task automatic reg_op(input logic [6:0] a, input logic wr, input logic [31:0] wd,
                        output logic [31:0] rd);
    logic [31:0] c;
    shift(1'b0, 8, {24'h0, wr, a}, c);
    shift(1'b0, 32, wd, rd);
  endtask
endmodule

/* sim/test_dsj_top.sv */
// Self-checking bench for the debug register access block.
// Assumes dsj_probe plays the debugger on the JTAG pins.
`timescale 1ns/1ps
module test_dsj_top;
  logic        clk_sys, rst, trst_n, debug_mode, enter_debug, core_retire;
  logic        cause_sleep, cause_hw_err, cause_hw_brk, cause_sw_brk, cause_step;
  logic        tck, tms, tdi, tdo, tdo_oe_n, inst_written, pc_written, dbg_access_mode;
  logic        imprecise_exec_keep, imprecise_bkpt_keep, return_stack_keep;
  logic        folding_keep, predict_keep;
  logic [7:0]  breakpoint_hit_bits;
  logic [31:0] core_pc, debug_instruction, debug_prog_counter, rd;
  int          fails = 0, n_checks = 0, cyc = 0;
  wire         tdo_w = tdo_oe_n ? 1'b1 : tdo;
  wire  [31:0] keeps = {26'h0, imprecise_exec_keep, imprecise_bkpt_keep,
                        return_stack_keep, folding_keep, predict_keep, 1'b0};
  dsj_top DUT (.*);
  dsj_probe u_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      conclude();
    end
  end
  // ==========================================
  // Compare, access and core tasks
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_probe.reg_op(a, 1'b1, d, x);
  endtask
  task automatic rd_chk(input string nm, input logic [6:0] a, input logic [31:0] e);
    u_probe.reg_op(a, 1'b0, 32'h0, rd);
    cmp(nm, e, rd);
  endtask
  // Status bits 7:5 lie outside this block and are not compared
  task automatic st_chk(input logic [4:0] c, input logic [7:0] bp);
    u_probe.reg_op(dsj_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
    cmp("status", {19'h0, bp, c}, {19'h0, rd[15:8], rd[4:0]});
  endtask
  task automatic core(input logic dm, input logic en, input logic [4:0] c, input logic [7:0] bp);
    @(posedge clk_sys);
    {cause_sleep, cause_hw_err, cause_hw_brk, cause_sw_brk, cause_step} <= c;
    {debug_mode, enter_debug, breakpoint_hit_bits} <= {dm, en, bp};
    @(posedge clk_sys);
    enter_debug <= 1'b0;
  endtask
  task automatic retire(input logic [31:0] pc);
    @(posedge clk_sys);
    {core_pc, core_retire} <= {pc, 1'b1};
    @(posedge clk_sys);
    core_retire <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {rst, trst_n, debug_mode, enter_debug, core_retire} <= 5'h10;
    {cause_sleep, cause_hw_err, cause_hw_brk, cause_sw_brk, cause_step} <= 5'h00;
    {core_pc, breakpoint_hit_bits} <= 40'h0;
    repeat (16) @(posedge clk_sys);
    {rst, trst_n} <= 2'h1;
    repeat (8) @(posedge clk_sys);
    cmp("inst_rst", 32'h0, debug_instruction);
    u_probe.to_reset();
    u_probe.shift(1'b0, 32, 32'h0, rd);
    cmp("idcode", dsj_pkg::IDCODE_VAL, rd);
    u_probe.shift(1'b1, 4, {28'h0, dsj_pkg::IR_DBG_ACC}, rd);
    cmp("mode_on", 32'h1, {31'h0, dbg_access_mode});
    retire(32'h0000_1000);
    retire(32'h0000_2004);
    rd_chk("pc_run", dsj_pkg::ADDR_PC, 32'h0000_2004);
    wr(dsj_pkg::ADDR_PC, 32'h5555_0000);
    rd_chk("pc_refused", dsj_pkg::ADDR_PC, 32'h0000_2004);
    for (int i = 0; i < 5; i++) begin
      core(1'b1, 1'b1, 5'h01 << i, (i == 2) ? 8'ha5 : 8'h00);
      st_chk(5'h01 << i, (i == 2) ? 8'ha5 : 8'h00);
      core(1'b0, 1'b0, 5'h00, 8'h00);
      rd_chk("status_exit", dsj_pkg::ADDR_STATUS, 32'h0);
    end
    core(1'b1, 1'b1, 5'h1f, 8'hff);
    wr(dsj_pkg::ADDR_STATUS, 32'h0000_0000);
    st_chk(5'h1f, 8'hff);
    rd_chk("pc_halt", dsj_pkg::ADDR_PC, 32'h0000_2004);
    wr(dsj_pkg::ADDR_PC, 32'h0000_3000);
    rd_chk("pc_set", dsj_pkg::ADDR_PC, 32'h0000_3000);
    cmp("pc_port", 32'h0000_3000, debug_prog_counter);
    core(1'b0, 1'b0, 5'h00, 8'h00);
    wr(dsj_pkg::ADDR_INST, 32'hdead_beef);
    cmp("inst_port", 32'hdead_beef, debug_instruction);
    rd_chk("inst", dsj_pkg::ADDR_INST, 32'hdead_beef);
    for (int i = 1; i < 6; i++) begin
      wr(dsj_pkg::ADDR_MASK, 32'h1 << i);
      cmp("keeps", 32'h1 << i, keeps);
    end
    wr(dsj_pkg::ADDR_MASK, 32'hffff_ffff);
    rd_chk("mask", dsj_pkg::ADDR_MASK, 32'h0000_003e);
    wr(7'h7f, 32'h1234_5678);
    rd_chk("unmapped", 7'h7f, 32'h0);
    rd_chk("mask_kept", dsj_pkg::ADDR_MASK, 32'h0000_003e);
    u_probe.shift(1'b1, 4, {28'h0, dsj_pkg::IR_BYPASS}, rd);
    cmp("mode_byp", 32'h0, {31'h0, dbg_access_mode});
    u_probe.shift(1'b1, 4, {28'h0, dsj_pkg::IR_DBG_ACC}, rd);
    u_probe.to_reset();
    cmp("mode_tlr", 32'h0, {31'h0, dbg_access_mode});
    @(posedge clk_sys);
    trst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cmp("trst", 32'h0, keeps | debug_instruction | {31'h0, ~tdo_oe_n});
    trst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    // JTAG reset seen earlier: first mask write is lost, debugger reselects debug access and reprograms
    wr(dsj_pkg::ADDR_MASK, 32'h0000_0002);
    cmp("keeps_lost", 32'h0, keeps);
    u_probe.to_reset();
    u_probe.shift(1'b1, 4, {28'h0, dsj_pkg::IR_DBG_ACC}, rd);
    wr(dsj_pkg::ADDR_MASK, 32'h0000_0002);
    cmp("keeps_again", 32'h0000_0002, keeps);
    conclude();
  end
endmodule
